// ### src/sbhie_map.vh
`ifndef SBHIE_MAP_VH
`define SBHIE_MAP_VH

`define SBHIE_OFF_EVT_SET      12'h080
`define SBHIE_OFF_EVT_CLR      12'h084
`define SBHIE_OFF_MSK_SET      12'h088
`define SBHIE_OFF_MSK_CLR      12'h08C
`define SBHIE_OFF_ISO_RX_MSK   12'h0A8
`define SBHIE_OFF_ISO_TX_MSK   12'h098

`define SBHIE_BIT_GLOBAL_EN    31
`define SBHIE_BIT_MAKER        30
`define SBHIE_BIT_SOFT         29
`define SBHIE_BIT_BUS_REINIT   17
`define SBHIE_BIT_ID_DONE      16
`define SBHIE_BIT_ID_STICKY    15
`define SBHIE_BIT_ISO_RX       7
`define SBHIE_BIT_ISO_TX       6

`define SBHIE_EVT_WMASK        32'h7FFF833F
`define SBHIE_MSK_WMASK        32'hEFFF83FF
`define SBHIE_EVT_RESET        32'h00000000
`define SBHIE_MSK_RESET        32'h00000000
`define SBHIE_ISO_RESET        8'h00

`endif

// ### src/sbhie_sync.v
`timescale 1ns/10ps
`default_nettype none
module sbhie_sync #(
	parameter W = 32
) (
	input  wire         sys_clk,
	input  wire         nrst,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// first stage is read by the second stage only
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### src/sbhie_top.v
`timescale 1ns/10ps
`default_nettype none
`include "sbhie_map.vh"
module sbhie_top #(
	parameter ISO_RX_CTX = 8,
	parameter ISO_TX_CTX = 8
) (
	input  wire                  sys_clk,
	input  wire                  nrst,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [11:0]           paddr,
	input  wire [31:0]           pwdata,
	output reg  [31:0]           prdata,
	output reg                   pready,
	output reg                   pslverr,
	input  wire [31:0]           evt_pulse,
	input  wire                  dma_int_cond,
	input  wire [ISO_RX_CTX-1:0] iso_rx_ctx_event,
	input  wire [ISO_TX_CTX-1:0] iso_tx_ctx_event,
	output reg                   irq_q
);
	// evt_pulse is a set of one-cycle strobes from block logic on sys_clk;
	// bit positions follow the event register.  bits 3..0 are dma completions,
	// gated by dma_int_cond, which the descriptor's interrupt field supplies.
	// the iso context event bits come from other clock logic and are synchronised.
	wire [ISO_RX_CTX-1:0] iso_rx_s;
	wire [ISO_TX_CTX-1:0] iso_tx_s;

	sbhie_sync #(.W(ISO_RX_CTX)) u_sync_rx (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (iso_rx_ctx_event),
		.sync_out (iso_rx_s)
	);

	sbhie_sync #(.W(ISO_TX_CTX)) u_sync_tx (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (iso_tx_ctx_event),
		.sync_out (iso_tx_s)
	);

	reg  [31:0]           evt_q;
	reg  [31:0]           evt_d;
	reg  [31:0]           msk_q;
	reg  [31:0]           msk_d;
	reg  [ISO_RX_CTX-1:0] iso_rx_msk_q;
	reg  [ISO_TX_CTX-1:0] iso_tx_msk_q;
	reg                   irq_d;
	wire                  wr_acc;
	wire                  rd_acc;
	wire                  iso_rx_sum;
	wire                  iso_tx_sum;
	wire [31:0]           hw_set;
	wire [31:0]           evt_view;

	function hit;
		input [11:0] a;
		input [11:0] off;
		begin
			hit = (a[11:2] == off[11:2]);
		end
	endfunction

	function known;
		input [11:0] a;
		begin
			known = hit(a, `SBHIE_OFF_EVT_SET) || hit(a, `SBHIE_OFF_EVT_CLR) ||
				hit(a, `SBHIE_OFF_MSK_SET) || hit(a, `SBHIE_OFF_MSK_CLR) ||
				hit(a, `SBHIE_OFF_ISO_RX_MSK) || hit(a, `SBHIE_OFF_ISO_TX_MSK);
		end
	endfunction

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;

	// summaries are never latched, so they clear as soon as the synchronised contexts do
	assign iso_rx_sum = |(iso_rx_s & iso_rx_msk_q);
	assign iso_tx_sum = |(iso_tx_s & iso_tx_msk_q);

	// dma completions only count when the descriptor asks for an interrupt
	assign hw_set = {evt_pulse[31:4],
		evt_pulse[3:0] & {4{dma_int_cond}}};

	// event view with live summaries; reserved bits dropped by the mask
	assign evt_view = ((evt_q & `SBHIE_EVT_WMASK) |
		({31'h00000000, iso_rx_sum} << `SBHIE_BIT_ISO_RX) |
		({31'h00000000, iso_tx_sum} << `SBHIE_BIT_ISO_TX)) & 32'hFFFF83FF;

	always @* begin
		evt_d = evt_q;
		if (wr_acc && hit(paddr, `SBHIE_OFF_EVT_CLR))
			evt_d = evt_d & ~pwdata;
		if (wr_acc && hit(paddr, `SBHIE_OFF_EVT_SET))
			evt_d = evt_d | pwdata;
		// hardware sets win over a same-cycle software clear
		evt_d = evt_d | hw_set;
		if (hw_set[`SBHIE_BIT_ID_DONE])
			evt_d[`SBHIE_BIT_ID_STICKY] = 1'b1;
		// a new bus reset cancels any id-done, even one arriving now
		if (hw_set[`SBHIE_BIT_BUS_REINIT] && !evt_q[`SBHIE_BIT_BUS_REINIT])
			evt_d[`SBHIE_BIT_ID_DONE] = 1'b0;
		evt_d = evt_d & `SBHIE_EVT_WMASK;
	end

	always @* begin
		msk_d = msk_q;
		if (wr_acc && hit(paddr, `SBHIE_OFF_MSK_CLR))
			msk_d = msk_d & ~pwdata;
		if (wr_acc && hit(paddr, `SBHIE_OFF_MSK_SET))
			msk_d = msk_d | pwdata;
		msk_d = msk_d & `SBHIE_MSK_WMASK;
	end

	always @* begin
		// mask aligns bit for bit with the event view, bit 31 excluded
		irq_d = msk_q[`SBHIE_BIT_GLOBAL_EN] &
			(|(evt_view[30:0] & msk_q[30:0]));
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			evt_q        <= `SBHIE_EVT_RESET;
			msk_q        <= `SBHIE_MSK_RESET;
			iso_rx_msk_q <= {ISO_RX_CTX{1'b0}};
			iso_tx_msk_q <= {ISO_TX_CTX{1'b0}};
			irq_q        <= 1'b0;
		end else begin
			evt_q <= evt_d;
			msk_q <= msk_d;
			irq_q <= irq_d;
			if (wr_acc && hit(paddr, `SBHIE_OFF_ISO_RX_MSK))
				iso_rx_msk_q <= pwdata[ISO_RX_CTX-1:0];
			if (wr_acc && hit(paddr, `SBHIE_OFF_ISO_TX_MSK))
				iso_tx_msk_q <= pwdata[ISO_TX_CTX-1:0];
		end
	end

	// no wait state: read data and pready are both registered in setup, so pready is high in the first access cycle
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~known(paddr);
			if (rd_acc) begin
				if (hit(paddr, `SBHIE_OFF_EVT_SET) || hit(paddr, `SBHIE_OFF_EVT_CLR))
					prdata <= evt_view;
				else if (hit(paddr, `SBHIE_OFF_MSK_SET) || hit(paddr, `SBHIE_OFF_MSK_CLR))
					prdata <= msk_q;
				else if (hit(paddr, `SBHIE_OFF_ISO_RX_MSK))
					prdata <= {{(32-ISO_RX_CTX){1'b0}}, iso_rx_msk_q};
				else if (hit(paddr, `SBHIE_OFF_ISO_TX_MSK))
					prdata <= {{(32-ISO_TX_CTX){1'b0}}, iso_tx_msk_q};
				else
					prdata <= 32'h00000000;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/sbhie_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sbhie_monitor (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq_q
);
	// register state is hidden here, so contents are judged by the bench
	wire hit = paddr[11:2] inside {10'h020, 10'h021, 10'h022, 10'h023, 10'h026, 10'h02A};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held");
	a_err_map: assert property (pready |-> pslverr == !hit)
		else $error("bad error flag");
	a_err_alone: assert property (pslverr |-> pready)
		else $error("stray error");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("error read not zero");
	a_rsvd_zero: assert property (pready && !pwrite |-> prdata[14:10] == 5'h00)
		else $error("reserved bits set");
	a_mask28_zero: assert property (pready && !pwrite && paddr[3] |-> !prdata[28])
		else $error("mask bit 28 set");
	a_global_off: assert property (psel && penable && pwrite && paddr == 12'h08C && pwdata[31]
		|=> ##1 !irq_q)
		else $error("irq despite global off");
endmodule
`default_nettype wire

// ### tb/sbhie_host.sv
`timescale 1ns/10ps
`default_nettype none
module sbhie_host (
	input wire logic sys_clk,
	input wire logic irq_q,
	output var int   hits
);
	logic seen_q = 1'b0;
	// level line: one service per rise, as a host would take it
	initial hits = 0;
	always @(posedge sys_clk) begin
		if (irq_q === 1'b1 && !seen_q)
			hits <= hits + 1;
		seen_q <= irq_q === 1'b1;
	end
endmodule
`default_nettype wire

// ### tb/sbhie_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, dma_int_cond = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, evt_pulse = 32'h00000000, prdata, r;
	logic [7:0]  iso_rx_ctx_event = 8'h00, iso_tx_ctx_event = 8'h00;
	logic        pready, pslverr, irq_q;
	int          miscompares = 0, num_checks = 0, hits;
	sbhie_top uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .evt_pulse, .dma_int_cond, .iso_rx_ctx_event, .iso_tx_ctx_event, .irq_q);
	sbhie_host host (.sys_clk, .irq_q, .hits);
	always #10 sys_clk = ~sys_clk;
	task chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
			miscompares++;
		end
	endtask
	// idle cycle between transfers keeps psel from two writes in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h00000000);
		chk(n, r, e);
	endtask
	task pulse(input logic [31:0] d, input logic c);
		@(posedge sys_clk);
		evt_pulse <= d;
		dma_int_cond <= c;
		@(posedge sys_clk);
		evt_pulse <= 32'h00000000;
	endtask
	task t_mask;
		rd(12'h0F0, 32'h00000000, "unmapped");
		apb(1'b1, 12'h088, 32'hFFFFFFFF);
		rd(12'h08C, 32'hEFFF83FF, "mask all");
		apb(1'b1, 12'h08C, 32'h00000000);
		rd(12'h088, 32'hEFFF83FF, "mask zeros");
		apb(1'b1, 12'h08C, 32'hFFFFFFFF);
		rd(12'h088, 32'h00000000, "mask clr");
	endtask
	task t_evt;
		pulse(32'hFFFFFFFF, 1'b1);
		rd(12'h080, 32'h7FFE833F, "events");
		apb(1'b1, 12'h084, 32'hFFFFFFFF);
		pulse(32'h0001000F, 1'b0);
		rd(12'h084, 32'h00018000, "id done");
		pulse(32'h00020000, 1'b0);
		rd(12'h080, 32'h00028000, "bus reset");
	endtask
	task t_irq;
		apb(1'b1, 12'h084, 32'hFFFFFFFF);
		apb(1'b1, 12'h088, 32'hA0000000);
		apb(1'b1, 12'h080, 32'h20000000);
		repeat (3) @(posedge sys_clk);
		chk("soft irq", irq_q, 1'b1);
		chk("hits", hits, 1);
		apb(1'b1, 12'h08C, 32'h80000000);
		repeat (3) @(posedge sys_clk);
		chk("global off", irq_q, 1'b0);
		apb(1'b1, 12'h088, 32'h80000000);
		apb(1'b1, 12'h08C, 32'h20000000);
		repeat (3) @(posedge sys_clk);
		chk("mask off", irq_q, 1'b0);
	endtask
	task t_iso;
		apb(1'b1, 12'h084, 32'hFFFFFFFF);
		apb(1'b1, 12'h0A8, 32'h00000001);
		apb(1'b1, 12'h098, 32'h00000080);
		iso_rx_ctx_event <= 8'h01;
		iso_tx_ctx_event <= 8'h80;
		repeat (4) @(posedge sys_clk);
		rd(12'h080, 32'h000000C0, "iso");
		iso_rx_ctx_event <= 8'h00;
		repeat (4) @(posedge sys_clk);
		rd(12'h080, 32'h00000040, "iso live");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		t_mask;
		t_evt;
		t_irq;
		t_iso;
		tally_and_finish;
	end
	initial begin
		#100000;
		miscompares++;
		tally_and_finish;
	end
endmodule
bind sbhie_top sbhie_monitor mon (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .irq_q);
`default_nettype wire
